// >>> src/uic_char_timer.sv
// counts character times without receive fifo traffic
`timescale 1ns/1ps
module uic_char_timer #(
	parameter int CHAR_TIMES = uic_pkg::CHAR_TIMES
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic restart,
	input  wire logic charTick,
	output logic      expired
);
	logic [3:0] count;

	// saturates at the limit so a stale fifo keeps the flag up
	always_ff @(posedge clock) begin
		if (sys_rst || restart)
			count <= 4'h0;
		else if (charTick && !expired)
			count <= count + 4'h1;
	end

	assign expired = (count == 4'(CHAR_TIMES));
endmodule : uic_char_timer

// >>> src/uic_irq_fifo_control.sv
// interrupt enable, identification and fifo control of the serial port
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - enable bit 0 allows data and timeout
// - enable bit 1 allows holding-empty interrupt
// - enable bit 2 allows line status interrupt
// - enable bit 3 allows modem status interrupt
// - enable bits 7..4 ignore writes, read zero
// - priority line, data, holding-empty, modem
// - identification frozen while host reads it
// - ident bit 0 low when anything pending
// - ident codes 1, 6, 4, C, 2, 0
// - bit 3 only on fifo timeout
// - each source cleared by its own access
// - ident and fifo bits 5..4 read zero
// - ident bits 7..6 mirror fifo enable
// - fifo enable bit; clearing empties both
// - receive fifo reset, self clearing
// - transmit fifo reset, self clearing
// - dma mode bit accepted, no effect
// - bits 7..6 choose 1, 4, 8, 14
// - offset 2 reads ident, writes fifo control
// - enable register at 1, latch bit low
// - interrupt output gated by output-2 bit
module uic_irq_fifo_control #(
	parameter int CNT_W      = 5,
	parameter int CHAR_TIMES = uic_pkg::CHAR_TIMES
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [2:0]       regAddr,
	input  wire logic [7:0]       regWdata,
	input  wire logic             regWr,
	input  wire logic             regRd,
	output logic      [7:0]       regRdata,
	input  wire logic             divisorLatchSelect,
	input  wire logic             irqOutputGate,
	input  wire logic             lineErrEvent,
	input  wire logic             txEmptyEvent,
	input  wire logic             modemChangeEvent,
	input  wire logic             rxPush,
	input  wire logic [CNT_W-1:0] rxCount,
	input  wire logic             charTick,
	output logic                  irq,
	output logic                  fifoEnable,
	output logic                  rxFifoFlush,
	output logic                  txFifoFlush,
	output logic      [4:0]       rxTrigLevel
);
	logic [3:0]         intEnable;
	logic               lineFlag;
	logic               txFlag;
	logic               modemFlag;
	logic [3:0]         identHeld;
	logic [3:0]         identNow;
	logic               timedOut;
	logic               rxAbove;
	logic               anyPend;
	uic_pkg::uic_pend_s pend;

	// decoded accesses
	logic ienWr;
	logic ienRd;
	logic identRd;
	logic fcWr;
	logic bufRd;
	logic thrWr;
	logic lsrRd;
	logic msrRd;
	logic modeChange;
	logic timerRestart;

	// strobe qualified by one register offset
	function automatic logic regHit(input logic strobe, input logic [2:0] addr, input logic [2:0] ofs);
		return strobe && addr == ofs;
	endfunction : regHit

	// a reset bit counts only in a write that also keeps the enable bit set
	function automatic logic fcBitSet(input logic [7:0] data, input int idx);
		return data[uic_pkg::FC_EN] && data[idx];
	endfunction : fcBitSet

	// latch bit hides data and enable offsets, not offset 2
	assign ienWr   = regHit(regWr, regAddr, uic_pkg::OFS_IEN) && !divisorLatchSelect;
	assign ienRd   = regHit(regRd, regAddr, uic_pkg::OFS_IEN) && !divisorLatchSelect;
	assign identRd = regHit(regRd, regAddr, uic_pkg::OFS_IDFC);
	assign fcWr    = regHit(regWr, regAddr, uic_pkg::OFS_IDFC);
	assign bufRd   = regHit(regRd, regAddr, uic_pkg::OFS_DATA) && !divisorLatchSelect;
	assign thrWr   = regHit(regWr, regAddr, uic_pkg::OFS_DATA) && !divisorLatchSelect;
	assign lsrRd   = regHit(regRd, regAddr, uic_pkg::OFS_LSR);
	assign msrRd   = regHit(regRd, regAddr, uic_pkg::OFS_MSR);

	// interrupt enable register, upper nibble not stored
	always_ff @(posedge clock) begin
		if (sys_rst)
			intEnable <= uic_pkg::IEN_RESET;
		else if (ienWr)
			intEnable <= regWdata[uic_pkg::IEN_W-1:0];
	end

	// fifo mode; a change of mode also empties both fifos
	assign modeChange = fcWr && (regWdata[uic_pkg::FC_EN] != fifoEnable);

	always_ff @(posedge clock) begin
		if (sys_rst)
			fifoEnable <= 1'b0;
		else if (fcWr)
			fifoEnable <= regWdata[uic_pkg::FC_EN];
	end

	// other fields only land with bit 0 set; dma bit is dropped
	always_ff @(posedge clock) begin
		if (sys_rst)
			rxTrigLevel <= uic_pkg::TRIG_1;
		else if (fcWr && regWdata[uic_pkg::FC_EN]) begin
			case (regWdata[uic_pkg::FC_TRHI:uic_pkg::FC_TRLO])
				2'h0:    rxTrigLevel <= uic_pkg::TRIG_1;
				2'h1:    rxTrigLevel <= uic_pkg::TRIG_4;
				2'h2:    rxTrigLevel <= uic_pkg::TRIG_8;
				default: rxTrigLevel <= uic_pkg::TRIG_14;
			endcase
		end
	end

	// flush pulses last one cycle, so the reset bits clear themselves
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rxFifoFlush <= 1'b0;
			txFifoFlush <= 1'b0;
		end else begin
			rxFifoFlush <= modeChange || (fcWr && fcBitSet(regWdata, uic_pkg::FC_RXRST));
			txFifoFlush <= modeChange || (fcWr && fcBitSet(regWdata, uic_pkg::FC_TXRST));
		end
	end

	// line status: sticky, read of line status clears, set wins
	always_ff @(posedge clock) begin
		if (sys_rst)
			lineFlag <= 1'b0;
		else if (lineErrEvent)
			lineFlag <= 1'b1;
		else if (lsrRd)
			lineFlag <= 1'b0;
	end

	// holding empty: cleared by holding write or ident read naming it
	always_ff @(posedge clock) begin
		if (sys_rst)
			txFlag <= 1'b0;
		else if (txEmptyEvent)
			txFlag <= 1'b1;
		else if (thrWr || (identRd && identHeld == uic_pkg::ID_TXE))
			txFlag <= 1'b0;
	end

	// modem status change: cleared by modem status read
	always_ff @(posedge clock) begin
		if (sys_rst)
			modemFlag <= 1'b0;
		else if (modemChangeEvent)
			modemFlag <= 1'b1;
		else if (msrRd)
			modemFlag <= 1'b0;
	end

	// any fifo traffic or an empty fifo restarts the character timer
	assign timerRestart = !fifoEnable || rxCount == '0 || rxPush || bufRd || rxFifoFlush;

	uic_char_timer #(
		.CHAR_TIMES (CHAR_TIMES)
	) u_timer (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.restart  (timerRestart),
		.charTick (charTick),
		.expired  (timedOut)
	);

	// data level drops by itself when the fifo falls below trigger
	assign rxAbove = fifoEnable ? (rxCount >= CNT_W'(rxTrigLevel)) : (rxCount != '0);

	// sources gated by their enable bits
	always_comb begin
		pend.lineStat  = intEnable[uic_pkg::IEN_LINE] && lineFlag;
		pend.rxData    = intEnable[uic_pkg::IEN_RX] && rxAbove;
		pend.rxTimeout = intEnable[uic_pkg::IEN_RX] && fifoEnable && timedOut;
		pend.txEmpty   = intEnable[uic_pkg::IEN_TX] && txFlag;
		pend.modem     = intEnable[uic_pkg::IEN_MODEM] && modemFlag;
	end

	assign anyPend = |pend;

	uic_prio_encode u_prio (
		.pend  (pend),
		.ident (identNow)
	);

	// held copy stops moving during the read strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			identHeld <= uic_pkg::ID_NONE;
		else if (!identRd)
			identHeld <= identNow;
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (sys_rst)
			regRdata <= 8'h00;
		else if (ienRd)
			regRdata <= {4'h0, intEnable};
		else if (identRd)
			regRdata <= {{2{fifoEnable}}, 2'b00, identHeld};
		else
			regRdata <= 8'h00;
	end

	// output registered, held low while the gate bit is clear
	always_ff @(posedge clock) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= irqOutputGate && anyPend;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_line_then_read;
		(pend.lineStat && !identRd) ##1 identRd;
	endsequence

	sequence s_fc_write_en;
		fcWr && regWdata[uic_pkg::FC_EN];
	endsequence

	a_ien_upper_zero: assert property (ienRd |=> regRdata[7:4] == 4'h0)
		else $error("enable upper bits not zero");

	a_line_first_id: assert property (s_line_then_read |=> regRdata[3:0] == uic_pkg::ID_LINE)
		else $error("line status not reported first");

	a_ident_frozen: assert property (identRd |=> identHeld == $past(identHeld))
		else $error("ident moved during read");

	a_pend_bit: assert property ((!identRd ##1 identRd) |=> regRdata[0] == !$past(anyPend, 2))
		else $error("pending bit wrong");

	a_no_tmo_bit: assert property (!fifoEnable |-> !identNow[3])
		else $error("timeout bit outside fifo mode");

	a_thr_clears: assert property ((thrWr && !txEmptyEvent) |=> !txFlag)
		else $error("holding write did not clear");

	a_id_reserved_bits: assert property (identRd |=> regRdata[5:4] == 2'b00
		&& regRdata[7:6] == {2{$past(fifoEnable)}})
		else $error("ident upper bits wrong");

	a_rx_flush_pulse: assert property ((s_fc_write_en and regWdata[uic_pkg::FC_RXRST])
		|=> rxFifoFlush ##1 (!rxFifoFlush || $past(fcWr)))
		else $error("receive flush not one pulse");

	a_tx_flush_pulse: assert property ((s_fc_write_en and regWdata[uic_pkg::FC_TXRST])
		|=> txFifoFlush ##1 (!txFifoFlush || $past(fcWr)))
		else $error("transmit flush not one pulse");

	a_disable_flushes: assert property ((fcWr && !regWdata[uic_pkg::FC_EN] && fifoEnable)
		|=> rxFifoFlush && txFifoFlush && !fifoEnable)
		else $error("disable did not empty fifos");

	a_trig_top: assert property ((s_fc_write_en and regWdata[7:6] == 2'h3)
		|=> rxTrigLevel == uic_pkg::TRIG_14)
		else $error("trigger level wrong");

	a_irq_gated: assert property (!irqOutputGate |=> !irq)
		else $error("interrupt not gated");

	a_irq_follows: assert property ((irqOutputGate && anyPend) |=> irq)
		else $error("interrupt not raised");

	a_latch_hides_ien: assert property ((regWr && regAddr == uic_pkg::OFS_IEN
		&& divisorLatchSelect) |=> $stable(intEnable))
		else $error("enable written with latch bit set");

	a_ien_keeps: assert property (!ienWr |=> $stable(intEnable))
		else $error("enable changed without a write");

	// sticky flags: an event on the edge of its clearing access still wins
	sequence s_tx_named_read;
		identRd && identHeld == uic_pkg::ID_TXE && !txEmptyEvent;
	endsequence

	a_line_set_wins: assert property (lineErrEvent |=> lineFlag)
		else $error("line event lost");

	a_line_read_clr: assert property ((lsrRd && !lineErrEvent) |=> !lineFlag)
		else $error("line status read did not clear");

	a_modem_set_wins: assert property (modemChangeEvent |=> modemFlag)
		else $error("modem event lost");

	a_modem_read_clr: assert property ((msrRd && !modemChangeEvent) |=> !modemFlag)
		else $error("modem status read did not clear");

	a_tx_set_wins: assert property (txEmptyEvent |=> txFlag)
		else $error("holding empty event lost");

	a_tx_id_clears: assert property (s_tx_named_read |=> !txFlag)
		else $error("ident read did not clear holding empty");

	// encoder: each code only while every higher source is quiet
	a_none_code: assert property (!anyPend |-> identNow == uic_pkg::ID_NONE)
		else $error("idle code wrong");

	a_line_code: assert property (pend.lineStat |-> identNow == uic_pkg::ID_LINE)
		else $error("line status code wrong");

	a_rxd_code: assert property ((pend.rxData && !pend.lineStat)
		|-> identNow == uic_pkg::ID_RXD)
		else $error("received data code wrong");

	a_tmo_code: assert property ((pend.rxTimeout && !pend.lineStat && !pend.rxData)
		|-> identNow == uic_pkg::ID_TMO)
		else $error("timeout code wrong");

	a_txe_code: assert property ((pend.txEmpty && !pend.lineStat && !pend.rxData
		&& !pend.rxTimeout) |-> identNow == uic_pkg::ID_TXE)
		else $error("holding empty code wrong");

	a_modem_code: assert property ((pend.modem && !pend.lineStat && !pend.rxData
		&& !pend.rxTimeout && !pend.txEmpty) |-> identNow == uic_pkg::ID_MODEM)
		else $error("modem code wrong");

	// mode and flush side effects of fifo control writes
	a_flush_mode_on: assert property ((fcWr && regWdata[uic_pkg::FC_EN] && !fifoEnable)
		|=> rxFifoFlush && txFifoFlush && fifoEnable)
		else $error("enable did not empty fifos");

	a_fc_no_bit0: assert property ((fcWr && !regWdata[uic_pkg::FC_EN]) |=> $stable(rxTrigLevel))
		else $error("trigger changed without enable bit");

	a_no_spurious_flush: assert property (!fcWr |=> !rxFifoFlush && !txFifoFlush)
		else $error("flush without a write");

	a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data outside read cycle");

	a_irq_drops: assert property (!anyPend |=> !irq)
		else $error("interrupt without pending source");
endmodule : uic_irq_fifo_control

// >>> src/uic_pkg.sv
// shared constants and types of the uart interrupt and fifo control block
package uic_pkg;
	// register offsets
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IEN  = 3'h1;
	localparam logic [2:0] OFS_IDFC = 3'h2;
	localparam logic [2:0] OFS_LSR  = 3'h5;
	localparam logic [2:0] OFS_MSR  = 3'h6;
	// interrupt enable fields
	localparam int IEN_RX    = 0;
	localparam int IEN_TX    = 1;
	localparam int IEN_LINE  = 2;
	localparam int IEN_MODEM = 3;
	localparam int IEN_W     = 4;
	localparam logic [3:0] IEN_RESET = 4'h0;
	// fifo control fields
	localparam int FC_EN    = 0;
	localparam int FC_RXRST = 1;
	localparam int FC_TXRST = 2;
	localparam int FC_TRLO  = 6;
	localparam int FC_TRHI  = 7;
	// identification codes, bits 3..0
	localparam logic [3:0] ID_NONE  = 4'h1;
	localparam logic [3:0] ID_LINE  = 4'h6;
	localparam logic [3:0] ID_RXD   = 4'h4;
	localparam logic [3:0] ID_TMO   = 4'hC;
	localparam logic [3:0] ID_TXE   = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;
	// receive trigger levels in bytes
	localparam logic [4:0] TRIG_1  = 5'h01;
	localparam logic [4:0] TRIG_4  = 5'h04;
	localparam logic [4:0] TRIG_8  = 5'h08;
	localparam logic [4:0] TRIG_14 = 5'h0E;
	// character times without fifo traffic before a timeout
	localparam int CHAR_TIMES = 4;

	// pending sources, already gated by their enables
	typedef struct packed {
		logic lineStat;
		logic rxData;
		logic rxTimeout;
		logic txEmpty;
		logic modem;
	} uic_pend_s;

	// winning source after prioritisation
	typedef enum logic [2:0] {
		SRC_NONE  = 3'b000,
		SRC_LINE  = 3'b001,
		SRC_RXD   = 3'b010,
		SRC_TMO   = 3'b011,
		SRC_TXE   = 3'b100,
		SRC_MODEM = 3'b101
	} uic_src_e;
endpackage : uic_pkg

// >>> src/uic_prio_encode.sv
// priority encoder from pending sources to identification code
`timescale 1ns/1ps
module uic_prio_encode (
	input  uic_pkg::uic_pend_s pend,
	output logic [3:0]         ident
);
	uic_pkg::uic_src_e src;

	// fixed priority, line status highest, modem lowest
	always_comb begin
		if (pend.lineStat)
			src = uic_pkg::SRC_LINE;
		else if (pend.rxData)
			src = uic_pkg::SRC_RXD;
		else if (pend.rxTimeout)
			src = uic_pkg::SRC_TMO;
		else if (pend.txEmpty)
			src = uic_pkg::SRC_TXE;
		else if (pend.modem)
			src = uic_pkg::SRC_MODEM;
		else
			src = uic_pkg::SRC_NONE;
	end

	// code per source
	always_comb begin
		case (src)
			uic_pkg::SRC_LINE:  ident = uic_pkg::ID_LINE;
			uic_pkg::SRC_RXD:   ident = uic_pkg::ID_RXD;
			uic_pkg::SRC_TMO:   ident = uic_pkg::ID_TMO;
			uic_pkg::SRC_TXE:   ident = uic_pkg::ID_TXE;
			uic_pkg::SRC_MODEM: ident = uic_pkg::ID_MODEM;
			default:            ident = uic_pkg::ID_NONE;
		endcase
	end
endmodule : uic_prio_encode

// >>> test/tb_top.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/1ps
module tb_top;
	logic       clock, sys_rst, regWr, regRd, divisorLatchSelect, irqOutputGate;
	logic       lineErrEvent, txEmptyEvent, modemChangeEvent, addByte, takeByte;
	logic       rxPush, charTick, irq, fifoEnable, rxFifoFlush, txFifoFlush;
	logic [2:0] regAddr;
	logic [7:0] regWdata;
	logic [7:0] regRdata;
	logic [4:0] rxCount;
	logic [4:0] rxTrigLevel;
	int         fail_count = 0;
	int         checked = 0;
	logic [3:0] codes [4] = '{uic_pkg::ID_RXD, uic_pkg::ID_TXE, uic_pkg::ID_LINE, uic_pkg::ID_MODEM};
	logic [4:0] trigs [4] = '{uic_pkg::TRIG_1, uic_pkg::TRIG_4, uic_pkg::TRIG_8, uic_pkg::TRIG_14};

	uic_irq_fifo_control dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .divisorLatchSelect(divisorLatchSelect),
		.irqOutputGate(irqOutputGate), .lineErrEvent(lineErrEvent), .txEmptyEvent(txEmptyEvent),
		.modemChangeEvent(modemChangeEvent), .rxPush(rxPush), .rxCount(rxCount), .charTick(charTick),
		.irq(irq), .fifoEnable(fifoEnable), .rxFifoFlush(rxFifoFlush), .txFifoFlush(txFifoFlush),
		.rxTrigLevel(rxTrigLevel));
	uic_fifo_model fifo (.clock(clock), .sys_rst(sys_rst), .rxFifoFlush(rxFifoFlush), .addByte(addByte),
		.takeByte(takeByte), .rxPush(rxPush), .rxCount(rxCount), .charTick(charTick));

	// 25 MHz clock
	always #20 clock = ~clock;

	task automatic results();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// one-cycle write; outputs settle one step after the taking edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clock);
		regWr <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1 chk(regRdata, exp);
	endtask : rd

	// mask bits: line error, tx empty, modem change, byte arrival
	task automatic pulse(input logic [3:0] m);
		@(posedge clock);
		{lineErrEvent, txEmptyEvent, modemChangeEvent, addByte} <= m;
		@(posedge clock);
		{lineErrEvent, txEmptyEvent, modemChangeEvent, addByte} <= 4'h0;
		repeat (2) @(posedge clock);
		#1;
	endtask : pulse

	task automatic take();
		@(posedge clock);
		takeByte <= 1'b1;
		@(posedge clock);
		takeByte <= 1'b0;
		@(posedge clock);
	endtask : take

	// clears every source by its own access
	task automatic clr();
		rd(uic_pkg::OFS_LSR, 8'h00);
		rd(uic_pkg::OFS_MSR, 8'h00);
		wr(uic_pkg::OFS_DATA, 8'h00);
		take();
	endtask : clr

	// hang guard, far beyond the few hundred cycles of the sequence
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		results();
	end

	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		{regWr, regRd, divisorLatchSelect, lineErrEvent, txEmptyEvent} = '0;
		{modemChangeEvent, addByte, takeByte, regAddr, regWdata} = '0;
		irqOutputGate = 1'b1;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		rd(uic_pkg::OFS_IDFC, 8'h01);
		rd(uic_pkg::OFS_IEN, 8'h00);
		chk({3'h0, rxTrigLevel}, 8'h01);
		wr(uic_pkg::OFS_IEN, 8'hFF);
		rd(uic_pkg::OFS_IEN, 8'h0F);
		// each enable bit alone lets exactly its own source through
		for (int i = 0; i < 4; i++) begin
			wr(uic_pkg::OFS_IEN, 8'h01 << i);
			pulse(4'hF);
			chk({7'h0, irq}, 8'h01);
			rd(uic_pkg::OFS_IDFC, {4'h0, codes[i]});
			clr();
		end
		rd(uic_pkg::OFS_IDFC, 8'h01);
		// all four pending, gate shut, then served in rank order
		@(posedge clock) irqOutputGate <= 1'b0;
		wr(uic_pkg::OFS_IEN, 8'h0F);
		pulse(4'hF);
		chk({7'h0, irq}, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'h06);
		@(posedge clock) irqOutputGate <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk({7'h0, irq}, 8'h01);
		rd(uic_pkg::OFS_LSR, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'h04);
		take();
		rd(uic_pkg::OFS_IDFC, 8'h02);
		rd(uic_pkg::OFS_IDFC, 8'h00);
		rd(uic_pkg::OFS_MSR, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'h01);
		chk({7'h0, irq}, 8'h00);
		// fifo mode on with both resets
		wr(uic_pkg::OFS_IDFC, 8'hC7);
		chk({fifoEnable, rxFifoFlush, txFifoFlush, rxTrigLevel}, 8'hEE);
		@(posedge clock);
		#1 chk({6'h0, rxFifoFlush, txFifoFlush}, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'hC1);
		// every trigger code, dma bit set, no flush expected
		for (int t = 0; t < 4; t++) begin
			wr(uic_pkg::OFS_IDFC, 8'(t << 6) | 8'h39);
			chk({rxFifoFlush, txFifoFlush, 1'b0, rxTrigLevel}, {3'h0, trigs[t]});
		end
		rd(uic_pkg::OFS_IDFC, 8'hC1);
		wr(uic_pkg::OFS_IDFC, 8'h49);
		repeat (3) pulse(4'h1);
		rd(uic_pkg::OFS_IDFC, 8'hC1);
		pulse(4'h1);
		rd(uic_pkg::OFS_IDFC, 8'hC4);
		take();
		rd(uic_pkg::OFS_DATA, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'hC1);
		repeat (48) @(posedge clock);
		rd(uic_pkg::OFS_IDFC, 8'hCC);
		rd(uic_pkg::OFS_DATA, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'hC1);
		// latch select high: offset 2 still works, offset 1 closed
		@(posedge clock) divisorLatchSelect <= 1'b1;
		wr(uic_pkg::OFS_IDFC, 8'h00);
		chk({6'h0, fifoEnable, rxFifoFlush}, 8'h01);
		@(posedge clock);
		#1 chk({3'h0, rxCount}, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'h01);
		wr(uic_pkg::OFS_IEN, 8'h00);
		rd(uic_pkg::OFS_IEN, 8'h00);
		@(posedge clock) divisorLatchSelect <= 1'b0;
		rd(uic_pkg::OFS_IEN, 8'h0F);
		// other bits without bit 0 are not programmed
		wr(uic_pkg::OFS_IDFC, 8'hC6);
		chk({2'h0, fifoEnable, rxTrigLevel}, 8'h04);
		// line error on the very edge of its clearing read: the set wins
		@(posedge clock);
		regRd        <= 1'b1;
		regAddr      <= uic_pkg::OFS_LSR;
		lineErrEvent <= 1'b1;
		@(posedge clock);
		regRd        <= 1'b0;
		lineErrEvent <= 1'b0;
		rd(uic_pkg::OFS_IDFC, 8'h06);
		rd(uic_pkg::OFS_LSR, 8'h00);
		rd(uic_pkg::OFS_IDFC, 8'h01);
		results();
	end
endmodule : tb_top

// >>> test/uic_fifo_model.sv
// receive fifo fill model on the far side of the control block
`timescale 1ns/1ps
module uic_fifo_model (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       rxFifoFlush,
	input  wire logic       addByte,
	input  wire logic       takeByte,
	output logic            rxPush,
	output logic      [4:0] rxCount,
	output logic            charTick
);
	logic [2:0] tickDiv;

	// fill count; a flush wins so no stale byte survives it
	always_ff @(posedge clock) begin
		if (sys_rst || rxFifoFlush) begin
			rxCount <= 5'h00;
		end else if (addByte && rxCount != 5'h10) begin
			rxCount <= rxCount + 5'h01;
		end else if (takeByte && rxCount != 5'h00) begin
			rxCount <= rxCount - 5'h01;
		end
	end

	// pushes dropped while flushing, like the real fifo
	assign rxPush = addByte && !rxFifoFlush;

	// one character time every eight clocks, free running
	always_ff @(posedge clock) begin
		tickDiv <= sys_rst ? 3'h0 : tickDiv + 3'h1;
	end
	assign charTick = (tickDiv == 3'h7);
endmodule : uic_fifo_model
